// ### rtl/smcl_defines.svh
// Constants for the serial message command link.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef SMCL_DEFINES_SVH
`define SMCL_DEFINES_SVH

`define SMCL_CLK_HZ 40000000
`define SMCL_BAUD 57600
`define SMCL_BIT_CYC (`SMCL_CLK_HZ / `SMCL_BAUD)
`define SMCL_CNT_W 16
`define SMCL_DATA_BITS 7
`define SMCL_FRAME_BITS 10
`define SMCL_MAX_LEN 255
`define SMCL_LEN_W 8
`define SMCL_CH_LF 7'h0a
`define SMCL_CH_CR 7'h0d
`define SMCL_CH_SEMI 7'h3b
`define SMCL_CH_QMARK 7'h3f
`define SMCL_CH_SPACE 7'h20

`endif

// ### rtl/smcl_pkg.sv
// Types for the serial message command link.
// Assumes smcl_defines.svh is on the include path.
`include "smcl_defines.svh"
package smcl_pkg;
    typedef struct packed {
        logic valid;
        logic [6:0] data;
    } smcl_char_t;

    typedef struct packed {
        logic valid;
        logic is_query;
        logic last;
        logic [6:0] data;
    } smcl_msg_t;
endpackage

// ### rtl/smcl_rx_char.sv
// Receiver for one ten-bit odd-parity character.
// Assumes rxd already synchronised to core_clk by the caller.
`include "smcl_defines.svh"
module smcl_rx_char #(
    parameter int BIT_CYC = `SMCL_BIT_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic rxd,
    output smcl_pkg::smcl_char_t char_out,
    output logic parity_err
);
    logic busy_reg;
    logic [`SMCL_CNT_W-1:0] cnt_reg;
    logic [3:0] bit_reg;
    logic [8:0] shift_reg;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            bit_reg <= '0;
            shift_reg <= '0;
            char_out <= '0;
            parity_err <= 1'b0;
        end else begin
            char_out.valid <= 1'b0;
            parity_err <= 1'b0;
            if (!busy_reg) begin
                if (!rxd) begin
                    busy_reg <= 1'b1;
                    cnt_reg <= `SMCL_CNT_W'(BIT_CYC / 2);
                    bit_reg <= '0;
                end
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end else begin
                cnt_reg <= `SMCL_CNT_W'(BIT_CYC - 1);
                bit_reg <= bit_reg + 1'b1;
                if (bit_reg == 4'h0) begin
                    // False start: line back high mid start bit
                    if (rxd)
                        busy_reg <= 1'b0;
                end else if (bit_reg < 4'(`SMCL_FRAME_BITS - 1)) begin
                    shift_reg <= {rxd, shift_reg[8:1]}; // [R01]
                end else begin
                    busy_reg <= 1'b0;
                    // Odd parity: data plus parity holds odd ones
                    if (rxd && ^shift_reg[8:1]) begin // [R01]
                        char_out.valid <= 1'b1;
                        char_out.data <= shift_reg[7:1];
                    end else begin
                        parity_err <= 1'b1; // [R14]
                    end
                end
            end
        end
    end
endmodule // smcl_rx_char

// ### rtl/smcl_link.sv
// Serial command link: character framing, message splitting, replies.
// Assumes rxd is an asynchronous pin; the command engine sits on
// core_clk and hands response characters one at a time.
`include "smcl_defines.svh"

// What this block and its host must do
// R01: Ten-bit characters, seven data, odd parity
// R02: Line feed ends a message, CR optional
// R03: Every response ends with CR LF
// R04: Split chained strings at each semicolon
// R05: Host keeps transmission within 255 characters
// R06: Command: mnemonic, space, data; no response
// R07: Query has question mark; needs response
// R08: Start response as soon as possible
// R09: Transmit only in reply to a query
// R10: Host sends command and terminator unbroken
// R11: Host waits 50 ms after a command
// R12: Host waits through response plus 50 ms
// R13: Host starts at most 20 per second
// R14: Drop characters failing odd parity check
module smcl_link #(
    parameter int BIT_CYC = `SMCL_BIT_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic rxd,
    output logic txd,
    output smcl_pkg::smcl_msg_t msg_out,
    output logic msg_end,
    output logic overflow,
    output logic parity_drop,
    output logic resp_req,
    input wire logic [6:0] resp_data,
    input wire logic resp_valid,
    input wire logic resp_done,
    output logic resp_ready
);
    typedef enum logic [3:0] {
        SMCL_TX_IDLE = 4'b0001,
        SMCL_TX_BODY = 4'b0010,
        SMCL_TX_CR = 4'b0100,
        SMCL_TX_LF = 4'b1000
    } smcl_tx_state_t;

    logic rxd_meta_reg;
    logic rxd_sync_reg;
    smcl_pkg::smcl_char_t rx_char;
    logic rx_perr;
    logic [`SMCL_LEN_W-1:0] len_reg;
    logic query_reg;
    logic pend_reg;
    logic too_long_reg;
    smcl_tx_state_t tx_state_reg;
    logic [3:0] tx_bit_reg;
    logic [`SMCL_CNT_W-1:0] tx_cnt_reg;
    logic [9:0] tx_shift_reg;
    logic tx_busy_reg;
    logic [6:0] tx_char;
    logic tx_load;

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= rxd;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    smcl_rx_char #(
        .BIT_CYC(BIT_CYC)
    ) u_rx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .rxd(rxd_sync_reg),
        .char_out(rx_char),
        .parity_err(rx_perr)
    );

    ////////////////////////////////////////////////////////////////////
    // Message parsing
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msg_out <= '0;
            msg_end <= 1'b0;
            overflow <= 1'b0;
            parity_drop <= 1'b0;
            len_reg <= '0;
            query_reg <= 1'b0;
            pend_reg <= 1'b0;
            too_long_reg <= 1'b0;
        end else begin
            msg_out.valid <= 1'b0;
            msg_end <= 1'b0;
            overflow <= 1'b0;
            parity_drop <= rx_perr; // [R14]
            if (resp_req && tx_state_reg == SMCL_TX_LF && tx_load)
                pend_reg <= 1'b0;
            if (rx_char.valid) begin
                if (!too_long_reg)
                    len_reg <= len_reg + 1'b1;
                if (len_reg == `SMCL_LEN_W'(`SMCL_MAX_LEN)) begin
                    too_long_reg <= 1'b1; // [R05]
                    overflow <= ~too_long_reg;
                end
                if (rx_char.data == `SMCL_CH_LF) begin
                    // Either LF alone or CR LF closes the string
                    msg_out.valid <= 1'b1; // [R02]
                    msg_out.last <= 1'b1;
                    msg_out.is_query <= query_reg;
                    msg_out.data <= `SMCL_CH_LF;
                    msg_end <= 1'b1;
                    if (query_reg)
                        pend_reg <= 1'b1; // [R07]
                    len_reg <= '0;
                    query_reg <= 1'b0;
                    too_long_reg <= 1'b0;
                end else if (rx_char.data == `SMCL_CH_CR) begin
                    // Swallowed: the LF after it ends the string [R02]
                end else if (rx_char.data == `SMCL_CH_SEMI) begin
                    msg_out.valid <= 1'b1; // [R04]
                    msg_out.last <= 1'b0;
                    msg_out.is_query <= query_reg;
                    msg_out.data <= `SMCL_CH_SEMI;
                    if (query_reg)
                        pend_reg <= 1'b1;
                    query_reg <= 1'b0;
                end else if (!too_long_reg
                        && len_reg != `SMCL_LEN_W'(`SMCL_MAX_LEN)) begin
                    // Commands pass through and raise no response
                    if (rx_char.data == `SMCL_CH_QMARK)
                        query_reg <= 1'b1; // [R07]
                    msg_out.valid <= 1'b1; // [R06]
                    msg_out.last <= 1'b0;
                    msg_out.is_query <= 1'b0;
                    msg_out.data <= rx_char.data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Response sequencer
    always_comb begin
        case (tx_state_reg)
            SMCL_TX_BODY: tx_char = resp_data;
            SMCL_TX_CR: tx_char = `SMCL_CH_CR;
            SMCL_TX_LF: tx_char = `SMCL_CH_LF;
            default: tx_char = resp_data;
        endcase
    end

    assign tx_load = !tx_busy_reg && (tx_state_reg != SMCL_TX_IDLE)
        && (tx_state_reg != SMCL_TX_BODY || resp_valid);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_reg <= SMCL_TX_IDLE;
            resp_req <= 1'b0;
            resp_ready <= 1'b0;
        end else begin
            resp_ready <= 1'b0;
            case (tx_state_reg)
                SMCL_TX_IDLE: begin
                    // Only an owed query answer opens a transmission
                    if (pend_reg && msg_end) begin // [R09]
                        tx_state_reg <= SMCL_TX_BODY; // [R08]
                        resp_req <= 1'b1;
                    end
                end
                SMCL_TX_BODY: begin
                    if (resp_done && !resp_valid)
                        tx_state_reg <= SMCL_TX_CR; // [R03]
                    else if (tx_load)
                        resp_ready <= 1'b1;
                end
                SMCL_TX_CR: begin
                    if (tx_load)
                        tx_state_reg <= SMCL_TX_LF; // [R03]
                end
                SMCL_TX_LF: begin
                    if (tx_load) begin
                        tx_state_reg <= SMCL_TX_IDLE; // [R03]
                        resp_req <= 1'b0;
                    end
                end
                default: tx_state_reg <= SMCL_TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit shifter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_busy_reg <= 1'b0;
            tx_bit_reg <= '0;
            tx_cnt_reg <= '0;
            tx_shift_reg <= '1;
            txd <= 1'b1;
        end else if (tx_load && !resp_ready) begin
            // Stop, odd parity, data, start
            tx_shift_reg <= {1'b1, ~^tx_char, tx_char, 1'b0}; // [R01]
            tx_busy_reg <= 1'b1;
            tx_bit_reg <= '0;
            tx_cnt_reg <= `SMCL_CNT_W'(BIT_CYC - 1);
            txd <= 1'b0;
        end else if (tx_busy_reg) begin
            if (tx_cnt_reg != '0) begin
                tx_cnt_reg <= tx_cnt_reg - 1'b1;
            end else if (tx_bit_reg == 4'(`SMCL_FRAME_BITS - 1)) begin
                tx_busy_reg <= 1'b0;
                txd <= 1'b1;
            end else begin
                tx_cnt_reg <= `SMCL_CNT_W'(BIT_CYC - 1);
                tx_bit_reg <= tx_bit_reg + 1'b1;
                tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                txd <= tx_shift_reg[1];
            end
        end
    end
endmodule // smcl_link

// ### tb/smcl_link_props.sv
// Port-level checker for smcl_link.
// Assumes smcl_pkg is compiled first; bound to every smcl_link.
module smcl_link_props #(
    parameter int BIT_CYC = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic txd,
    input wire smcl_pkg::smcl_msg_t msg_out,
    input wire logic msg_end,
    input wire logic parity_drop,
    input wire logic resp_req,
    input wire logic resp_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // Cycles since a response was last owed
    logic [15:0] idle_cnt;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            idle_cnt <= 16'h0000;
        else if (resp_req)
            idle_cnt <= 16'h0000;
        else if (idle_cnt != 16'hffff)
            idle_cnt <= idle_cnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_lf_last;
        msg_out.valid && msg_out.data == 7'h0a |-> msg_out.last;
    endproperty
    a_lf_last: assert property (p_lf_last)
        else $error("line feed not marked last");
    property p_no_cr;
        msg_out.valid |-> msg_out.data != 7'h0d;
    endproperty
    a_no_cr: assert property (p_no_cr)
        else $error("carriage return forwarded");
    property p_semi_split;
        msg_out.valid && msg_out.data == 7'h3b |-> !msg_out.last;
    endproperty
    a_semi_split: assert property (p_semi_split)
        else $error("semicolon marked last");
    property p_msg_pulse;
        msg_out.valid |=> !msg_out.valid;
    endproperty
    a_msg_pulse: assert property (p_msg_pulse)
        else $error("message valid longer than one cycle");
    property p_query_req;
        msg_out.valid && msg_out.last && msg_out.is_query |-> ##[1:2] resp_req;
    endproperty
    a_query_req: assert property (p_query_req)
        else $error("query not answered promptly");
    property p_req_cause;
        $rose(resp_req) |-> $past(msg_end);
    endproperty
    a_req_cause: assert property (p_req_cause)
        else $error("response owed without a message end");
    property p_tx_idle;
        int'(idle_cnt) > 11 * BIT_CYC |-> txd;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("transmit line active with no response owed");
    property p_drop_quiet;
        parity_drop |-> !msg_out.valid [*4];
    endproperty
    a_drop_quiet: assert property (p_drop_quiet)
        else $error("bad character forwarded");
    property p_ready_owed;
        resp_ready |-> resp_req;
    endproperty
    a_ready_owed: assert property (p_ready_owed)
        else $error("response character taken while none owed");
endmodule // smcl_link_props

bind smcl_link smcl_link_props #(.BIT_CYC(BIT_CYC)) u_props (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .txd(txd),
    .msg_out(msg_out),
    .msg_end(msg_end),
    .parity_drop(parity_drop),
    .resp_req(resp_req),
    .resp_ready(resp_ready)
);

// ### tb/smcl_host.sv
// Host model: sends characters on rxd, collects response frames on txd.
// Assumes callers start send one step after a rising edge.
module smcl_host #(
    parameter int BIT_CYC = 8
) (
    input wire logic core_clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] got_q[$];
    int frame_err = 0;
    initial rxd = 1'b1;
    // Start, data LSB first, odd parity (inverted on request), stop
    task automatic send(input logic [6:0] c, input logic bad);
        logic [9:0] f;
        f = {1'b1, ~^c ^ bad, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (BIT_CYC) @(posedge core_clk);
            #1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Samples each response frame mid-bit and checks its framing
    initial begin
        logic [9:0] f;
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge core_clk);
            for (int i = 0; i < 10; i++) begin
                f[i] = txd;
                if (i < 9)
                    repeat (BIT_CYC) @(posedge core_clk);
            end
            if (f[0] !== 1'b0 || f[9] !== 1'b1 || ^f[8:1] !== 1'b1)
                frame_err++;
            got_q.push_back(f[7:1]);
        end
    end
endmodule // smcl_host

// ### tb/serial_message_command_link_test.sv
// Self-checking bench for smcl_link with a host model on the serial side.
// Assumes the design, smcl_host and the checker are compiled beforehand.
module serial_message_command_link_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 8;
    localparam int GAP = 200;
    logic core_clk, arst_n, rxd, txd, msg_end, overflow, parity_drop;
    logic resp_req, resp_valid, resp_done, resp_ready;
    logic [6:0] resp_data;
    smcl_pkg::smcl_msg_t msg_out;
    logic [6:0] msg_q[$];
    int n_mismatch = 0, num_checks = 0, n_end = 0, n_ovf = 0, n_drop = 0;
    int n_qry = 0;
    smcl_link #(.BIT_CYC(BC)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .rxd(rxd), .txd(txd), .msg_out(msg_out), .msg_end(msg_end),
        .overflow(overflow), .parity_drop(parity_drop),
        .resp_req(resp_req), .resp_data(resp_data),
        .resp_valid(resp_valid), .resp_done(resp_done),
        .resp_ready(resp_ready));
    smcl_host #(.BIT_CYC(BC)) u_host (.core_clk(core_clk), .txd(txd),
        .rxd(rxd));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (msg_out.valid === 1'b1)
            msg_q.push_back(msg_out.data);
        n_end += int'(msg_end === 1'b1);
        n_ovf += int'(overflow === 1'b1);
        n_drop += int'(parity_drop === 1'b1);
        n_qry += int'(msg_out.valid === 1'b1 && msg_out.is_query === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole string with its terminator, unbroken
    task automatic send_str(input string s);
        byte ch;
        for (int i = 0; i < s.len(); i++) begin
            ch = s[i];
            u_host.send(ch[6:0], 1'b0);
        end
    endtask
    // Quiet spacing after each transmission, scaled down
    task automatic gap;
        repeat (GAP) @(posedge core_clk);
        #1;
    endtask
    task automatic check_msg(input string s);
        int k;
        byte ch;
        k = 0;
        repeat (BC * 2) @(posedge core_clk);
        #1;
        for (int i = 0; i < s.len(); i++) begin
            ch = s[i];
            if (ch != 8'h0d) begin
                check(msg_q[k], ch[6:0], "msg char");
                k++;
            end
        end
        check(msg_q.size(), k, "msg count");
        msg_q.delete();
    endtask
    // Engine side: supplies a random body, then expects it plus CR LF
    task automatic answer(input int n);
        logic [6:0] body[$];
        int w;
        for (w = 0; w < 200 && resp_req !== 1'b1; w++) @(posedge core_clk);
        check(resp_req, 1'b1, "resp owed");
        #1;
        for (int i = 0; i < n; i++) begin
            body.push_back(7'h21 + 7'($urandom_range(80)));
            resp_data = body[i];
            resp_valid = 1'b1;
            for (w = 0; w < 2000 && resp_ready !== 1'b1; w++)
                @(posedge core_clk);
            #1;
        end
        resp_valid = 1'b0;
        resp_done = 1'b1;
        for (w = 0; w < 4000 && resp_req !== 1'b0; w++) @(posedge core_clk);
        #1;
        resp_done = 1'b0;
        repeat (BC * 12) @(posedge core_clk);
        #1;
        body.push_back(7'h0d);
        body.push_back(7'h0a);
        check(u_host.got_q.size(), body.size(), "resp len");
        foreach (body[i]) check(u_host.got_q[i], body[i], "resp");
        check(u_host.frame_err, 0, "frame");
        u_host.got_q.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        string s;
        arst_n = 1'b0;
        resp_data = 7'h00;
        resp_valid = 1'b0;
        resp_done = 1'b0;
        void'($urandom(12469));
        repeat (20) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        send_str("AB 5\n");
        check_msg("AB 5\n");
        check(resp_req, 1'b0, "command quiet");
        check(u_host.got_q.size(), 0, "no reply");
        gap();
        send_str("Q?\r\n");
        answer($urandom_range(6, 1));
        check_msg("Q?\n");
        gap();
        send_str("X 1;Y?\n");
        answer($urandom_range(6, 1));
        check_msg("X 1;Y?\n");
        gap();
        u_host.send(7'h4b, 1'b0);
        u_host.send(7'h57, 1'b1);
        send_str(" 2\n");
        check_msg("K 2\n");
        check(n_drop, 1, "drop");
        gap();
        repeat (3) begin
            s = "";
            repeat ($urandom_range(8, 1))
                s = $sformatf("%s%c", s, 8'(65 + $urandom_range(25)));
            s = {s, " 7\n"};
            send_str(s);
            check_msg(s);
            gap();
        end
        s = "";
        repeat (256) s = {s, "A"};
        send_str({s, "\n"});
        repeat (BC * 2) @(posedge core_clk);
        #1;
        check(n_ovf, 1, "overflow");
        check(msg_q.size(), 256, "kept chars");
        check(n_qry, 2, "query ends");
        check(n_end, 8, "message ends");
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        $display("wrong value at %0t: run did not finish", $time);
        complete_run();
    end
endmodule // serial_message_command_link_test
